/* design/sevq_pkg.sv */
// Package: register map, fields, reset values and carriers of the status block
// Summary of operation
// RULE1 - An event sets its event register bit, which stays set until read or cleared.
// RULE2 - Reading an event register returns its contents, then clears that register.
// RULE3 - Power-up and clear-status clear all event registers; preset leaves them.
// RULE4 - Summary bit is OR of event AND enable; it drives a status byte bit.
// RULE5 - Enable registers are 16 bits, written 0 to FFFF, and read back.
// RULE6 - Writing 0 to an enable register clears all its bits.
// RULE7 - Power-up and preset clear enable registers; clear-status leaves them.
// RULE8 - Output queue is a FIFO; message-available bit tracks non-empty.
// RULE9 - Reading a message from the output queue removes it.
// RULE10 - Host sends the query first, then reads the output queue.
// RULE11 - A queued error sets error-available; it clears when the queue empties.
// RULE12 - Error queue holds ten entries; one read returns and removes oldest.
// RULE13 - When the error queue fills, the last slot gets overflow code 350.
// RULE14 - Reading an empty error queue returns code 0, no error.
// RULE15 - Entries carry signed codes: negative standard, positive vendor defined.
// RULE16 - Power-up enables error codes, disables status codes; resets keep filter.
// RULE17 - Enable list admits only listed ranges; disable list removes listed ones.
// RULE18 - An enable list with no ranges blocks every message.
// RULE19 - Queue reads: next, all with clear, count without removal, and clear. The all read here returns only the oldest entry.
// RULE20 - Power-up and clear-status empty the error queue; preset leaves it.
// RULE21 - Status byte: error-available at bit 2, master summary at bit 6.
// RULE22 - Once overflow holds the last slot, new messages drop until space frees.
package sevq_pkg;

  // Register byte offsets
  localparam logic [7:0] EV_BASE     = 8'h00; // Four event registers, RC
  localparam logic [7:0] EN_BASE     = 8'h10; // Four enable registers, RW
  localparam logic [7:0] STB_OFF     = 8'h20; // Status byte, RO
  localparam logic [7:0] CMD_OFF     = 8'h24; // Command strobes, WO
  localparam logic [7:0] FRANGE_OFF  = 8'h28; // Filter range lo/hi, RW
  localparam logic [7:0] OQ_DATA_OFF = 8'h2C; // Output queue head, pops
  localparam logic [7:0] OQ_CNT_OFF  = 8'h30; // Output queue count, RO
  localparam logic [7:0] EQ_NEXT_OFF = 8'h34; // Error queue head, pops
  localparam logic [7:0] EQ_ALL_OFF  = 8'h38; // Error queue head, clears all
  localparam logic [7:0] EQ_CNT_OFF  = 8'h3C; // Error queue count, RO

  // Command register bits
  localparam int CMD_CLS     = 0; // Clear status
  localparam int CMD_PRESET  = 1; // Status preset
  localparam int CMD_EQ_CLR  = 2; // Clear error queue
  localparam int CMD_FEN_CLR = 3; // Start a new enable list (empties filter)
  localparam int CMD_FEN_ADD = 4; // Add range to enabled set
  localparam int CMD_FDIS    = 5; // Add range to disabled set

  // Status byte bit positions
  localparam int STB_MEAS = 0;
  localparam int STB_EAV  = 2;
  localparam int STB_QUES = 3;
  localparam int STB_MAV  = 4;
  localparam int STB_ESB  = 5;
  localparam int STB_MSS  = 6;
  localparam int STB_OPER = 7;

  // Event register set indices and the query-error bit of standard event
  localparam int EV_STD  = 0;
  localparam int EV_OPER = 1;
  localparam int EV_MEAS = 2;
  localparam int EV_QUES = 3;
  localparam int EV_N    = 4;
  localparam int STD_QYE = 2;

  // Reset values and queue figures
  localparam logic [15:0] EV_RST   = 16'h0000;
  localparam logic [15:0] EN_RST   = 16'h0000;
  localparam int          EQ_DEPTH = 10;
  localparam int          OQ_DEPTH = 8;
  localparam int          OQ_W     = 32;
  localparam int          FILT_N   = 8;

  // Signed message codes
  typedef logic signed [15:0] sevq_code_t;
  localparam sevq_code_t CODE_OVERFLOW = 16'sd350;
  localparam sevq_code_t CODE_NONE     = 16'sd0;
  localparam sevq_code_t ERR_LO_RST    = -16'sd32768;
  localparam sevq_code_t ERR_HI_RST    = -16'sd1;

  typedef logic [15:0] sevq_word_t;

  // Incoming error or status message
  typedef struct packed {
    logic       valid;
    sevq_code_t code;
  } sevq_err_t;

  // One filter range slot
  typedef struct packed {
    logic       vld;
    logic       dis;
    sevq_code_t lo;
    sevq_code_t hi;
  } sevq_filt_t;

  localparam sevq_filt_t FILT_EMPTY = '{1'b0, 1'b0, 16'sd0, 16'sd0};
  localparam sevq_filt_t FILT_ERR_ALL = '{1'b1, 1'b0, ERR_LO_RST, ERR_HI_RST};

endpackage

/* design/sevq_top.sv */
// Status event registers, enable masks, output queue and error queue on APB
//
// Added by the designer: the placing of the registers and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module sevq_top
  import sevq_pkg::*;
#(
  parameter int OQ_DEP = OQ_DEPTH,
  parameter int OQ_WID = OQ_W,
  parameter int EQ_DEP = EQ_DEPTH
) (
  // Clock and reset
  input  wire logic                clk,
  input  wire logic                reset_n,
  // APB slave
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  // Event sources, one pulse or level per bit
  input  wire sevq_word_t [EV_N-1:0] ev_set,
  // Response messages into the output queue
  input  wire logic                oq_push,
  input  wire logic [OQ_WID-1:0]   oq_data,
  output logic                     oq_full,
  // Error and status messages
  input  wire sevq_err_t           err_in,
  // Status byte
  output logic [7:0]               status_byte
);

  localparam int OQ_PW = (OQ_DEP > 1) ? $clog2(OQ_DEP) : 1;
  localparam int OQ_CW = $clog2(OQ_DEP + 1);
  localparam int EQ_PW = $clog2(EQ_DEP);
  localparam int EQ_CW = $clog2(EQ_DEP + 1);

  // Refuse sizes the logic cannot serve: pointers go through an 8-bit
  // wrap helper, queue words must fit the bus, slot count fits 4 bits
  if (OQ_DEP < 2 || OQ_DEP > 256) begin : g_bad_oq_dep
    $error("sevq_top: output queue depth out of range");
  end
  if (OQ_WID < 1 || OQ_WID > 32) begin : g_bad_oq_wid
    $error("sevq_top: output queue width out of range");
  end
  if (EQ_DEP < 2 || EQ_DEP > 256) begin : g_bad_eq_dep
    $error("sevq_top: error queue depth out of range");
  end
  if (FILT_N > 15) begin : g_bad_filt
    $error("sevq_top: too many filter slots for the slot counter");
  end

  // Next pointer with wrap for any depth
  function automatic logic [7:0] wrap_inc(input logic [7:0] p,
                                          input int dep);
    wrap_inc = (int'(p) == dep - 1) ? 8'h00 : p + 8'h01;
  endfunction

  // True when a code falls in an enabled range and no disabled range
  function automatic logic code_pass(input sevq_code_t c,
                                     input sevq_filt_t t [FILT_N]);
    logic en;
    logic dis;
    en  = 1'b0;
    dis = 1'b0;
    for (int k = 0; k < FILT_N; k++) begin
      if (t[k].vld && c >= t[k].lo && c <= t[k].hi) begin
        if (t[k].dis) begin
          dis = 1'b1;
        end else begin
          en = 1'b1;
        end
      end
    end
    code_pass = en && !dis;
  endfunction

  // Bus answer, register state and queue storage
  logic [31:0]      prdata_q;
  logic             pready_q;
  logic             pslverr_q;
  logic             rd_ok_q;
  logic [7:0]       stb_q;
  sevq_word_t       ev_q [EV_N];
  sevq_word_t       en_q [EV_N];
  sevq_word_t       ev_in [EV_N];
  logic [31:0]      frange_q;
  sevq_filt_t       filt_q [FILT_N];
  logic [3:0]       fcnt_q;
  logic [OQ_WID-1:0] oq_mem [OQ_DEP];
  logic [OQ_PW-1:0] oq_rd_q;
  logic [OQ_PW-1:0] oq_wr_q;
  logic [OQ_CW-1:0] oq_cnt_q;
  logic             oq_full_q;
  sevq_code_t       eq_mem [EQ_DEP];
  logic [EQ_PW-1:0] eq_rd_q;
  logic [EQ_PW-1:0] eq_wr_q;
  logic [EQ_CW-1:0] eq_cnt_q;
  logic [31:0]      rd_data_d;
  logic             rd_ok_d;
  logic             map_ok_d;
  logic [EV_N-1:0]  summ;

  // Bus phases: setup loads read data, access completes with pready
  // Side effects happen only at the edge that completes the access
  wire logic setup = psel && !penable;
  wire logic acc   = psel && penable && pready_q;
  wire logic wr    = acc && pwrite;
  wire logic rd    = acc && !pwrite;
  wire logic cmd_w = wr && paddr == CMD_OFF;
  wire logic cls   = cmd_w && pwdata[CMD_CLS];
  wire logic pre   = cmd_w && pwdata[CMD_PRESET];

  // Read mux and address check, evaluated during setup
  always_comb begin
    rd_data_d = 32'h0000_0000;
    rd_ok_d   = 1'b1;
    map_ok_d  = 1'b1;
    case (paddr)
      EV_BASE:            rd_data_d = {16'h0000, ev_q[0]};
      EV_BASE + 8'h04:    rd_data_d = {16'h0000, ev_q[1]};
      EV_BASE + 8'h08:    rd_data_d = {16'h0000, ev_q[2]};
      EV_BASE + 8'h0C:    rd_data_d = {16'h0000, ev_q[3]};
      EN_BASE:            rd_data_d = {16'h0000, en_q[0]}; // [RULE5]
      EN_BASE + 8'h04:    rd_data_d = {16'h0000, en_q[1]};
      EN_BASE + 8'h08:    rd_data_d = {16'h0000, en_q[2]};
      EN_BASE + 8'h0C:    rd_data_d = {16'h0000, en_q[3]};
      STB_OFF:            rd_data_d = {24'h000000, stb_q};
      CMD_OFF:            rd_data_d = 32'h0000_0000;
      FRANGE_OFF:         rd_data_d = frange_q;
      OQ_DATA_OFF: begin
        rd_ok_d   = oq_cnt_q != '0;
        rd_data_d = rd_ok_d ? 32'(oq_mem[oq_rd_q]) : 32'h0000_0000;
      end
      OQ_CNT_OFF:         rd_data_d = 32'(oq_cnt_q);
      EQ_NEXT_OFF, EQ_ALL_OFF: begin
        // Empty queue answers with the no-error code
        rd_ok_d   = eq_cnt_q != '0;
        rd_data_d = rd_ok_d ? {{16{eq_mem[eq_rd_q][15]}}, eq_mem[eq_rd_q]}
                            : {{16{CODE_NONE[15]}}, CODE_NONE}; // [RULE14] [RULE15]
      end
      EQ_CNT_OFF:         rd_data_d = 32'(eq_cnt_q); // [RULE19]
      default:            map_ok_d = 1'b0;
    endcase
    // Writes reach only the enable, command and range registers
    if (pwrite && !(paddr[7:4] == EN_BASE[7:4] || paddr == CMD_OFF ||
                    paddr == FRANGE_OFF)) begin
      map_ok_d = 1'b0;
    end
  end

  // APB answer: one setup cycle, one access cycle, data from flip-flops
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      pready_q  <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q  <= 32'h0000_0000;
      rd_ok_q   <= 1'b0;
    end else begin
      pready_q  <= setup;
      pslverr_q <= setup && !map_ok_d;
      if (setup) begin
        prdata_q <= pwrite ? 32'h0000_0000 : rd_data_d;
        rd_ok_q  <= rd_ok_d;
      end
    end
  end

  // Event registers latch sources; a read clears only the bits it returned
  for (genvar i = 0; i < EV_N; i++) begin : g_ev
    wire logic rd_me = rd && paddr == 8'(EV_BASE + 8'(4 * i));
    // Reading an empty output queue raises the query-error event
    wire logic qye   = (i == EV_STD) && rd && paddr == OQ_DATA_OFF &&
                       !rd_ok_q;
    always_comb begin
      ev_in[i] = ev_set[i];
      ev_in[i][STD_QYE] = ev_set[i][STD_QYE] | qye;
    end
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        ev_q[i] <= EV_RST; // [RULE3]
      end else if (cls) begin
        ev_q[i] <= ev_in[i]; // [RULE3] new events win over the clear
      end else if (rd_me) begin
        ev_q[i] <= (ev_q[i] & ~prdata_q[15:0]) | ev_in[i]; // [RULE2]
      end else begin
        ev_q[i] <= ev_q[i] | ev_in[i]; // [RULE1]
      end
    end
    // Summary of enabled events
    assign summ[i] = |(ev_q[i] & en_q[i]); // [RULE4]
  end

  // Enable registers: whole 16-bit value written, preset clears
  for (genvar i = 0; i < EV_N; i++) begin : g_en
    always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
        en_q[i] <= EN_RST; // [RULE7]
      end else if (pre) begin
        en_q[i] <= EN_RST; // [RULE7]
      end else if (wr && paddr == 8'(EN_BASE + 8'(4 * i))) begin
        en_q[i] <= pwdata[15:0]; // [RULE5] [RULE6]
      end
    end
  end

  // Filter range staging register
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      frange_q <= 32'h0000_0000;
    end else if (wr && paddr == FRANGE_OFF) begin
      frange_q <= pwdata;
    end
  end

  // Message filter: list of enable and disable ranges, kept over clear-status and preset
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      for (int k = 0; k < FILT_N; k++) begin
        filt_q[k] <= (k == 0) ? FILT_ERR_ALL : FILT_EMPTY; // [RULE16]
      end
      fcnt_q <= 4'h1;
    // Adds past the last slot are ignored; an add with a new list uses slot 0
    end else if (cmd_w) begin
      if (pwdata[CMD_FEN_CLR]) begin
        for (int k = 0; k < FILT_N; k++) begin
          filt_q[k] <= FILT_EMPTY; // [RULE17] [RULE18]
        end
        fcnt_q <= 4'h0;
      end
      if ((pwdata[CMD_FEN_ADD] || pwdata[CMD_FDIS]) &&
          (pwdata[CMD_FEN_CLR] || int'(fcnt_q) < FILT_N)) begin
        filt_q[pwdata[CMD_FEN_CLR] ? 0 : int'(fcnt_q)] <=
          '{1'b1, pwdata[CMD_FDIS], frange_q[15:0], frange_q[31:16]}; // [RULE17]
        fcnt_q <= pwdata[CMD_FEN_CLR] ? 4'h1 : fcnt_q + 4'h1;
      end
    end
  end

  // Error queue control
  wire logic eq_pop = rd && paddr == EQ_NEXT_OFF && rd_ok_q; // [RULE12]
  wire logic eq_clr = cls || (cmd_w && pwdata[CMD_EQ_CLR]) ||
                      (rd && paddr == EQ_ALL_OFF); // [RULE19] [RULE20]
  // Occupancy after this cycle's pop or clear, so a push may use the room
  wire logic [EQ_CW-1:0] eq_eff = eq_clr ? '0 :
                                  eq_cnt_q - EQ_CW'(eq_pop);
  wire logic eq_push = err_in.valid && code_pass(err_in.code, filt_q) &&
                       int'(eq_eff) < EQ_DEP; // [RULE22]
  // The push that would fill the queue stores the overflow marker instead
  wire logic eq_last = int'(eq_eff) == EQ_DEP - 1;
  wire logic [EQ_PW-1:0] eq_wslot = eq_clr ? '0 : eq_wr_q;

  // Error queue storage: the final free slot takes the overflow marker
  always_ff @(posedge clk) begin
    if (eq_push) begin
      eq_mem[eq_wslot] <= eq_last ? CODE_OVERFLOW : err_in.code; // [RULE13]
    end
  end

  // Error queue pointers and count
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      eq_rd_q  <= '0; // [RULE20]
      eq_wr_q  <= '0;
      eq_cnt_q <= '0;
    end else begin
      eq_cnt_q <= eq_eff + EQ_CW'(eq_push);
      if (eq_clr) begin
        eq_rd_q <= '0;
      end else if (eq_pop) begin
        eq_rd_q <= EQ_PW'(wrap_inc(8'(eq_rd_q), EQ_DEP)); // [RULE12]
      end
      if (eq_push) begin
        eq_wr_q <= EQ_PW'(wrap_inc(8'(eq_wslot), EQ_DEP));
      end else if (eq_clr) begin
        eq_wr_q <= '0;
      end
    end
  end

  // Output queue control
  wire logic oq_pop = rd && paddr == OQ_DATA_OFF && rd_ok_q; // [RULE9]
  wire logic oq_in  = oq_push && int'(oq_cnt_q) < OQ_DEP;
  // Pushes while full are dropped, even with a pop; below full, a push and a pop together keep the count
  wire logic [OQ_CW-1:0] oq_nxt = oq_cnt_q + OQ_CW'(oq_in) -
                                  OQ_CW'(oq_pop);

  // Output queue storage
  always_ff @(posedge clk) begin
    if (oq_in) begin
      oq_mem[oq_wr_q] <= oq_data; // [RULE8]
    end
  end

  // Output queue pointers, count and full flag
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      oq_rd_q   <= '0;
      oq_wr_q   <= '0;
      oq_cnt_q  <= '0;
      oq_full_q <= 1'b0;
    end else begin
      oq_cnt_q  <= oq_nxt;
      oq_full_q <= int'(oq_nxt) == OQ_DEP;
      if (oq_in) begin
        oq_wr_q <= OQ_PW'(wrap_inc(8'(oq_wr_q), OQ_DEP));
      end
      if (oq_pop) begin
        oq_rd_q <= OQ_PW'(wrap_inc(8'(oq_rd_q), OQ_DEP)); // [RULE9]
      end
    end
  end

  // Status byte from summaries and queue occupancy
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      stb_q <= 8'h00;
    end else begin
      stb_q           <= 8'h00;
      stb_q[STB_MEAS] <= summ[EV_MEAS]; // [RULE4]
      stb_q[STB_QUES] <= summ[EV_QUES];
      stb_q[STB_ESB]  <= summ[EV_STD];
      stb_q[STB_OPER] <= summ[EV_OPER];
      stb_q[STB_EAV]  <= eq_cnt_q != '0; // [RULE11] [RULE21]
      stb_q[STB_MAV]  <= oq_cnt_q != '0; // [RULE8]
      stb_q[STB_MSS]  <= (|summ) || eq_cnt_q != '0 ||
                         oq_cnt_q != '0; // [RULE21]
    end
  end

  // Outputs straight from their flip-flops
  assign prdata      = prdata_q;
  assign pready      = pready_q;
  assign pslverr     = pslverr_q;
  assign oq_full     = oq_full_q;
  assign status_byte = stb_q;

endmodule
`default_nettype wire

/* testbench/sevq_top_asserts.sv */
// Port checker of the status event and queue block
`timescale 1ns/1ns
`default_nettype none
module sevq_top_asserts
  import sevq_pkg::*;
#(
  parameter int OQ_DEP = OQ_DEPTH,
  parameter int OQ_WID = OQ_W,
  parameter int EQ_DEP = EQ_DEPTH
) (
  // Clock and reset
  input wire logic                  clk,
  input wire logic                  reset_n,
  // APB
  input wire logic                  psel,
  input wire logic                  penable,
  input wire logic                  pwrite,
  input wire logic [7:0]            paddr,
  input wire logic [31:0]           pwdata,
  input wire logic [31:0]           prdata,
  // Sources and status
  input wire sevq_word_t [EV_N-1:0] ev_set,
  input wire logic                  oq_push,
  input wire logic                  oq_full,
  input wire sevq_err_t             err_in,
  input wire logic [7:0]            status_byte
);
  default clocking @(posedge clk); endclocking
  default disable iff (!reset_n);

  // Read setup cycle
  wire rds = psel && !penable && !pwrite;

  chk_event_latch: assert property (ev_set[EV_OPER] != 0
    ##1 !psel [*3] ##1 (rds && paddr == EV_BASE + 8'h04) |=>
    (prdata[15:0] & $past(ev_set[EV_OPER], 5)) == $past(ev_set[EV_OPER], 5))
    else $error("operation event bit lost before its read");
  chk_read_clear: assert property ((rds && paddr == EV_BASE &&
    ev_set[EV_STD] == 0) ##1 ev_set[EV_STD] == 0 [*2]
    ##1 (rds && paddr == EV_BASE) |=> prdata == 32'h0)
    else $error("standard event register not cleared by its read");
  chk_en_readback: assert property ((psel && penable && pwrite &&
    paddr == EN_BASE) ##1 !psel ##1 (rds && paddr == EN_BASE) |=>
    prdata == {16'h0, $past(pwdata[15:0], 3)})
    else $error("enable register read back differs from written value");
  chk_mav_set: assert property (oq_push && !oq_full && !psel |=>
    ##1 status_byte[STB_MAV])
    else $error("message available missing after a push");
  chk_eav_set: assert property ((rds && paddr == EQ_CNT_OFF)
    ##1 prdata != 0 ##1 !psel |-> status_byte[STB_EAV])
    else $error("error available low with entries queued");
  chk_eq_bound: assert property (rds && paddr == EQ_CNT_OFF |=>
    prdata <= 32'(EQ_DEP))
    else $error("error queue count above its depth");
  chk_empty_code: assert property (rds && paddr == EQ_NEXT_OFF &&
    !status_byte[STB_EAV] && !$past(err_in.valid) |=> prdata == 32'h0)
    else $error("empty error queue read not zero");
  chk_mss_or: assert property (status_byte[STB_MSS] ==
    (|{status_byte[7], status_byte[5:0]}))
    else $error("master summary differs from other status bits");
endmodule

bind sevq_top sevq_top_asserts #(
  .OQ_DEP(OQ_DEP), .OQ_WID(OQ_WID), .EQ_DEP(EQ_DEP)
) sevq_top_asserts_i (
  .clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .ev_set(ev_set), .oq_push(oq_push), .oq_full(oq_full),
  .err_in(err_in), .status_byte(status_byte)
);
`default_nettype wire

/* testbench/sevq_host.sv */
// Bus host model: APB master sending queries and commands
`timescale 1ns/1ns
`default_nettype none
module sevq_host (
  // Clock
  input  wire logic        clk,
  // APB master side
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [7:0]       paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  // Bus idle from time zero
  initial {psel, penable, pwrite, paddr, pwdata} = '0;

  // One transfer: setup cycle, then access held until pready, then bus released
  task automatic xfer(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] r,
                      output logic e);
    @(posedge clk);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a;
    pwdata  <= ~d;
  endtask
endmodule
`default_nettype wire

/* testbench/sevq_top_test.sv */
// Self-checking bench of the status event and queue block
`timescale 1ns/1ns
`default_nettype none
module sevq_top_test
  import sevq_pkg::*;
;
  logic                  clk = 1'b0, reset_n = 1'b0, oq_push = 1'b0;
  logic                  psel, penable, pwrite, pready, pslverr, oq_full, er;
  logic [7:0]            paddr, status_byte;
  logic [31:0]           pwdata, prdata, r, oq_data = '0;
  sevq_word_t [EV_N-1:0] ev_set = '0;
  sevq_err_t             err_in = '0;
  int                    fails = 0, checks = 0;
  localparam int SB [EV_N] = '{STB_ESB, STB_OPER, STB_MEAS, STB_QUES};

  // Clock
  always #50 clk = ~clk;

  // Device and bus host
  sevq_top sevq_top_i (.clk(clk), .reset_n(reset_n), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .ev_set(ev_set),
    .oq_push(oq_push), .oq_data(oq_data), .oq_full(oq_full),
    .err_in(err_in), .status_byte(status_byte));
  sevq_host sevq_host_i (.clk(clk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  // Compare and count
  task automatic ck(input string n, input logic [31:0] e, g);
    checks++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    sevq_host_i.xfer(1'b0, a, 32'h0, r, er);
    ck($sformatf("reg %h", a), e, r);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    sevq_host_i.xfer(1'b1, a, d, r, er);
  endtask
  // Source pulses: event bits, output queue words, error codes
  task automatic evp(input int i, input sevq_word_t v);
    @(posedge clk);
    ev_set[i] <= v;
    @(posedge clk);
    ev_set[i] <= '0;
    repeat (2) @(posedge clk);
  endtask
  task automatic oqp(input logic [31:0] d);
    @(posedge clk);
    oq_push <= 1'b1;
    oq_data <= d;
    @(posedge clk);
    oq_push <= 1'b0;
  endtask
  task automatic ep(input sevq_code_t c);
    @(posedge clk);
    err_in <= '{1'b1, c};
    @(posedge clk);
    err_in <= '{1'b0, CODE_NONE};
  endtask

  task automatic t_reset();
    for (int i = 0; i < EV_N; i++) begin
      rd(EV_BASE + 8'(4 * i), 32'h0);
      rd(EN_BASE + 8'(4 * i), 32'h0);
    end
    rd(EQ_CNT_OFF, 32'h0);
    sevq_host_i.xfer(1'b0, 8'h40, 32'h0, r, er);
    ck("unmapped error", 32'h1, 32'(er));
  endtask

  task automatic t_events();
    for (int i = 0; i < EV_N; i++) begin
      evp(i, 16'h8001);
      rd(EV_BASE + 8'(4 * i), 32'h8001);
      rd(EV_BASE + 8'(4 * i), 32'h0);
      wr(EN_BASE + 8'(4 * i), 32'hFFFF);
      rd(EN_BASE + 8'(4 * i), 32'hFFFF);
      evp(i, 16'h0100);
      ck("summary", 32'h1, 32'(status_byte[SB[i]]));
      ck("master", 32'h1, 32'(status_byte[STB_MSS]));
      wr(EN_BASE + 8'(4 * i), 32'h0);
      rd(EN_BASE + 8'(4 * i), 32'h0);
      ck("summary", 32'h0, 32'(status_byte[SB[i]]));
      rd(EV_BASE + 8'(4 * i), 32'h0100);
    end
  endtask

  task automatic t_resets();
    evp(EV_STD, 16'h0010);
    ep(-16'sd7);
    wr(EN_BASE, 32'h00FF);
    wr(CMD_OFF, 32'(1 << CMD_PRESET));
    rd(EN_BASE, 32'h0);
    rd(EQ_CNT_OFF, 32'h1);
    rd(EV_BASE, 32'h0010);
    evp(EV_STD, 16'h0010);
    wr(EN_BASE, 32'h00FF);
    wr(CMD_OFF, 32'(1 << CMD_CLS));
    rd(EV_BASE, 32'h0);
    rd(EN_BASE, 32'h00FF);
    rd(EQ_CNT_OFF, 32'h0);
    ep(-16'sd2);
    ep(16'sd2);
    rd(EQ_NEXT_OFF, 32'hFFFFFFFE);
    rd(EQ_CNT_OFF, 32'h0);
    wr(EN_BASE, 32'h0);
  endtask

  task automatic t_outq();
    oqp(32'hA5A50001);
    oqp(32'h00000002);
    repeat (2) @(posedge clk);
    ck("mav", 32'h1, 32'(status_byte[STB_MAV]));
    rd(OQ_DATA_OFF, 32'hA5A50001);
    rd(OQ_CNT_OFF, 32'h1);
    rd(OQ_DATA_OFF, 32'h2);
    rd(OQ_DATA_OFF, 32'h0);
    ck("mav", 32'h0, 32'(status_byte[STB_MAV]));
    rd(EV_BASE, 32'(1 << STD_QYE));
    for (int i = 0; i <= OQ_DEPTH; i++) oqp(32'h100 + 32'(i));
    @(posedge clk);
    ck("oq_full", 32'h1, 32'(oq_full));
    rd(OQ_CNT_OFF, 32'(OQ_DEPTH));
    for (int i = 0; i < OQ_DEPTH; i++) begin
      rd(OQ_DATA_OFF, 32'h100 + 32'(i));
    end
    ck("oq_full", 32'h0, 32'(oq_full));
  endtask

  task automatic t_errq();
    ep(16'sd5);
    for (int i = 1; i <= 12; i++) ep(sevq_code_t'(-i));
    rd(EQ_CNT_OFF, 32'(EQ_DEPTH));
    ck("eav", 32'h1, 32'(status_byte[STB_EAV]));
    for (int i = 1; i < EQ_DEPTH; i++) rd(EQ_NEXT_OFF, 32'(-i));
    rd(EQ_NEXT_OFF, 32'(CODE_OVERFLOW));
    rd(EQ_NEXT_OFF, 32'h0);
    ck("eav", 32'h0, 32'(status_byte[STB_EAV]));
  endtask

  task automatic t_filter();
    wr(FRANGE_OFF, 32'h00070003);
    wr(CMD_OFF, 32'((1 << CMD_FEN_CLR) | (1 << CMD_FEN_ADD)));
    ep(16'sd5);
    ep(-16'sd1);
    rd(EQ_CNT_OFF, 32'h1);
    rd(EQ_NEXT_OFF, 32'h5);
    wr(FRANGE_OFF, 32'h00050005);
    wr(CMD_OFF, 32'(1 << CMD_FDIS));
    ep(16'sd5);
    ep(16'sd4);
    rd(EQ_NEXT_OFF, 32'h4);
    wr(CMD_OFF, 32'(1 << CMD_FEN_CLR));
    ep(-16'sd1);
    ep(16'sd4);
    rd(EQ_CNT_OFF, 32'h0);
    wr(FRANGE_OFF, 32'hFFFF8000);
    wr(CMD_OFF, 32'((1 << CMD_FEN_CLR) | (1 << CMD_FEN_ADD)));
    ep(-16'sd3);
    ep(-16'sd4);
    rd(EQ_ALL_OFF, 32'hFFFFFFFD);
    rd(EQ_CNT_OFF, 32'h0);
    ep(-16'sd5);
    rd(EQ_CNT_OFF, 32'h1);
    wr(CMD_OFF, 32'(1 << CMD_EQ_CLR));
    rd(EQ_CNT_OFF, 32'h0);
  endtask

  // Verdict and end of run
  task automatic conclude();
    $display("checks %0d fails %0d", checks, fails);
    if (fails == 0 && checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  // Main sequence
  initial begin
    repeat (8) @(posedge clk);
    reset_n <= 1'b1;
    t_reset();
    t_events();
    t_resets();
    t_outq();
    t_errq();
    t_filter();
    conclude();
  end

  // Watchdog
  initial begin
    repeat (20000) @(posedge clk);
    fails++;
    conclude();
  end
endmodule
`default_nettype wire
